/* File: gsi_i2c_target.sv */
`timescale 1ns/1ps
`default_nettype none
module gsi_i2c_target
  import gsi_pkg::*;
#(
  parameter int       DEPTH    = 2,
  parameter logic [7:0] RAM_FIRST = RAM_BASE
) (
  // Core clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  // I2C link
  input  wire logic       link_clk_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            scl_out,
  output logic            scl_oe_out,
  output logic            sda_out,
  output logic            sda_oe_out,
  // NVM area load
  input  wire logic       nvm_we_in,
  input  wire logic [7:0] nvm_addr_in,
  input  wire logic [7:0] nvm_data_in,
  // RAM write notification stream
  output logic            wr_valid_out,
  input  wire logic       wr_ready_in,
  output gsi_wr_t         wr_out
);

  localparam int ANS_MAX = FAST_HALF_CYC;

  // ----------------------------------------------------------------------
  // Link domain: synchronisers
  // ----------------------------------------------------------------------
  logic       lrst_meta, lrst;
  logic [2:0] scl_s, sda_s;
  logic [1:0] ack_s;
  logic       ack_tgl, req_tgl, next_req_tgl;
  logic       scl_rise, scl_fall, start_cond, stop_cond, done;

  always_ff @(posedge link_clk_in) begin
    lrst_meta <= rst_in;
    lrst      <= lrst_meta;
    scl_s     <= {scl_s[1:0], scl_in};
    sda_s     <= {sda_s[1:0], sda_in};
    ack_s     <= {ack_s[0], ack_tgl};
  end

  assign scl_rise   = scl_s[1] & ~scl_s[2];
  assign scl_fall   = ~scl_s[1] & scl_s[2];
  assign start_cond = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
  assign stop_cond  = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];
  assign done       = (ack_s[1] == req_tgl);

  // ----------------------------------------------------------------------
  // Link domain: byte engine
  // ----------------------------------------------------------------------
  gsi_state_t state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [7:0] sh, next_sh, ptr, next_ptr, rdata;
  logic       first, next_first, rw, next_rw, nack, next_nack;
  logic       next_sda_oe, next_scl_oe;
  gsi_req_t   req, next_req;

  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_sh      = sh;
    next_ptr     = ptr;
    next_first   = first;
    next_rw      = rw;
    next_nack    = nack;
    next_req     = req;
    next_req_tgl = req_tgl;
    if (stop_cond) begin
      next_state = ST_IDLE;
    end else if (start_cond) begin
      next_state = ST_ADDR;
      next_cnt   = 4'h0;
    end else begin
      case (state)
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            next_sh  = {sh[6:0], sda_s[1]};
            next_cnt = cnt + 4'h1;
          end else if (scl_fall && cnt == BITS_BYTE) begin
            if (state == ST_ADDR) begin
              next_rw    = sh[0];
              next_state = (sh[7:1] == TGT_ADDR) ? ST_ADDR_ACK : ST_IDLE;
            end else if (first) begin
              next_ptr   = sh;
              next_state = ST_RX_ACK;
            end else begin
              next_req   = '{wr: 1'b1, addr: ptr, data: sh};
              next_state = ST_REQ;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            next_cnt   = 4'h0;
            next_first = 1'b1;
            next_req   = '{wr: 1'b0, addr: ptr, data: 8'h00};
            next_state = rw ? ST_REQ : ST_RX;
          end
        end
        ST_RX_ACK: begin
          if (scl_fall) begin
            next_cnt   = 4'h0;
            next_first = 1'b0;
            next_state = ST_RX;
          end
        end
        ST_REQ: begin
          if (done) begin
            next_req_tgl = ~req_tgl;
            next_state   = ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (done) begin
            next_ptr = ptr + 8'h01;
            next_cnt = 4'h0;
            if (req.wr) begin
              next_state = ST_RX_ACK;
            end else begin
              next_sh    = rdata;
              next_state = ST_TX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (cnt == BITS_BYTE - 4'h1) begin
              next_state = ST_TX_ACK;
            end else begin
              next_sh  = {sh[6:0], 1'b1};
              next_cnt = cnt + 4'h1;
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            next_nack = sda_s[1];
          end else if (scl_fall) begin
            next_req   = '{wr: 1'b0, addr: ptr, data: 8'h00};
            next_state = nack ? ST_IDLE : ST_REQ;
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
    next_sda_oe = (next_state == ST_ADDR_ACK) || (next_state == ST_RX_ACK) ||
                  ((next_state == ST_TX) && !next_sh[7]);
    // Hold SCL low while a register access crosses, and one cycle after.
    next_scl_oe = (next_state == ST_REQ) || (next_state == ST_WAIT) || (state == ST_WAIT);
  end

  always_ff @(posedge link_clk_in) begin
    if (lrst) begin
      state      <= ST_IDLE;
      cnt        <= 4'h0;
      sh         <= 8'h00;
      ptr        <= PTR_RESET;
      first      <= 1'b0;
      rw         <= 1'b0;
      nack       <= 1'b0;
      req        <= '0;
      req_tgl    <= 1'b0;
      sda_oe_out <= 1'b0;
      scl_oe_out <= 1'b0;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      sh         <= next_sh;
      ptr        <= next_ptr;
      first      <= next_first;
      rw         <= next_rw;
      nack       <= next_nack;
      req        <= next_req;
      req_tgl    <= next_req_tgl;
      sda_oe_out <= next_sda_oe;
      scl_oe_out <= next_scl_oe;
    end
  end

  assign sda_out = 1'b0;
  assign scl_out = 1'b0;

  // ----------------------------------------------------------------------
  // Core domain: register array and access server
  // ----------------------------------------------------------------------
  logic [7:0] mem [256];
  logic [1:0] req_s;
  logic       next_ack_tgl, pending, ram_hit, serve, ram_we, buf_ready;
  logic [7:0] next_rdata, mem_at_req;

  always_ff @(posedge ref_clk_in) begin
    req_s <= {req_s[0], req_tgl};
  end

  always_comb begin
    mem_at_req   = mem[req.addr];
    pending      = (req_s[1] != ack_tgl);
    ram_hit      = (req.addr >= RAM_FIRST);
    ram_we       = pending & req.wr & ram_hit & buf_ready;
    serve        = pending & (!req.wr | !ram_hit | buf_ready);
    next_ack_tgl = ack_tgl ^ serve;
    next_rdata   = (serve && !req.wr) ? mem_at_req : rdata;
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ack_tgl <= 1'b0;
      rdata   <= 8'h00;
    end else begin
      ack_tgl <= next_ack_tgl;
      rdata   <= next_rdata;
    end
    if (ram_we) begin
      mem[req.addr] <= req.data;
    end else if (nvm_we_in) begin
      mem[nvm_addr_in] <= nvm_data_in;
    end
  end

  gsi_fifo #(
    .W     ($bits(gsi_wr_t)),
    .DEPTH (DEPTH)
  ) u_wr_buf (
    .clk_in        (ref_clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (pending & req.wr & ram_hit),
    .in_ready_out  (buf_ready),
    .in_data_in    ({req.addr, req.data}),
    .out_valid_out (wr_valid_out),
    .out_ready_in  (wr_ready_in),
    .out_data_out  (wr_out)
  );

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_addr_match;
    @(posedge link_clk_in) disable iff (lrst)
    state == ST_ADDR_ACK |-> sh[7:1] == TGT_ADDR;
  endproperty
  a_addr_match: assert property (p_addr_match) else $error("acked a foreign address");

  property p_req_ptr;
    @(posedge link_clk_in) disable iff (lrst)
    state == ST_REQ |-> req.addr == ptr;
  endproperty
  a_req_ptr: assert property (p_req_ptr) else $error("access not at pointer");

  property p_ptr_inc;
    @(posedge link_clk_in) disable iff (lrst)
    (state == ST_WAIT && done) |=> ptr == $past(ptr) + 8'h01;
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) else $error("pointer did not step");

  property p_ptr_wrap;
    @(posedge link_clk_in) disable iff (lrst)
    (state == ST_WAIT && done && ptr == PTR_LAST) |=> ptr == 8'h00;
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer did not wrap");

  property p_read_answer;
    @(posedge ref_clk_in) disable iff (rst_in)
    $rose(pending && !req.wr) |-> ##[1:ANS_MAX] !pending;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer too late");

  property p_nvm_ro;
    @(posedge ref_clk_in) disable iff (rst_in)
    (serve && req.wr && !ram_hit && !nvm_we_in) |=> mem_at_req == $past(mem_at_req);
  endproperty
  a_nvm_ro: assert property (p_nvm_ro) else $error("write reached NVM area");

  property p_read_data;
    @(posedge ref_clk_in) disable iff (rst_in)
    (serve && !req.wr) |=> rdata == $past(mem_at_req);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data wrong");

  property p_ram_keep;
    @(posedge ref_clk_in) disable iff (rst_in)
    (serve && req.wr && ram_hit) |=> mem_at_req == $past(req.data);
  endproperty
  a_ram_keep: assert property (p_ram_keep) else $error("RAM write lost");

endmodule : gsi_i2c_target
`default_nettype wire

/* File: gsi_pkg.sv */
// Notes on behaviour
// - Target works at standard mode up to 100 kHz and fast mode up to 400 kHz.
// - Out of reset the target answers 7-bit address 0x32 and ignores all others.
// - Controller loads the pointer in a write; later reads and writes use it.
// - Pointer increments by one after every register byte, in either direction.
// - Incrementing the pointer from 0xff wraps it to 0x00.
// - Writes store only into RAM registers; reads return NVM and RAM alike.
// - Registers 0x88 to 0x8b keep any written value and read it back.
`default_nettype none
package gsi_pkg;

  // ----------------------------------------------------------------------
  // Addresses and reset values
  // ----------------------------------------------------------------------
  localparam logic [6:0] TGT_ADDR  = 7'h32;
  localparam logic [7:0] RAM_BASE  = 8'h80;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] PTR_LAST  = 8'hff;
  localparam logic [3:0] BITS_BYTE = 4'h8;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int REF_CLK_KHZ   = 125000;
  localparam int STD_SCL_KHZ   = 100;
  localparam int FAST_SCL_KHZ  = 400;
  localparam int FAST_HALF_CYC = REF_CLK_KHZ / (2 * FAST_SCL_KHZ);

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } gsi_req_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } gsi_wr_t;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_ADDR     = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_RX       = 4'h3,
    ST_RX_ACK   = 4'h4,
    ST_REQ      = 4'h5,
    ST_WAIT     = 4'h6,
    ST_TX       = 4'h7,
    ST_TX_ACK   = 4'h8
  } gsi_state_t;

endpackage : gsi_pkg
`default_nettype wire

/* File: gsi_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module gsi_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // Filling side
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  // Draining side
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  store [DEPTH];
  logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [AW:0]   count, next_count;
  logic          push, pop;

  assign in_ready_out  = (count != (AW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out  = store[rd_ptr];

  always_comb begin
    push        = in_valid_in & in_ready_out;
    pop         = out_valid_out & out_ready_in;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (push) begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
    end
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
    if (push) begin
      store[wr_ptr] <= in_data_in;
    end
  end

endmodule : gsi_fifo
`default_nettype wire

/* File: gsi_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module gsi_host_model (
  // Wire levels
  input  wire logic scl_in,
  input  wire logic sda_in,
  // Pull-downs, high while this side holds the wire low
  output logic      scl_low_out,
  output logic      sda_low_out
);
  int half_ns = 300;

  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
  end

  // Releases SCL, then waits out any stretch by the target, with a bound.
  task automatic rise();
    scl_low_out = 1'b0;
    for (int n = 0; n < 200000 && scl_in !== 1'b1; n++) #1;
    #(half_ns);
  endtask : rise

  // Serves for a first start and for a repeated start alike.
  task automatic start();
    sda_low_out = 1'b0;
    #(half_ns);
    rise();
    sda_low_out = 1'b1;
    #(half_ns);
    scl_low_out = 1'b1;
  endtask : start

  task automatic stop();
    sda_low_out = 1'b1;
    #(half_ns);
    rise();
    sda_low_out = 1'b0;
    #(half_ns);
  endtask : stop

  task automatic bit_io(input logic b, output logic s);
    sda_low_out = ~b;
    #(half_ns);
    rise();
    s = sda_in;
    scl_low_out = 1'b1;
  endtask : bit_io

  task automatic put(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : put

  // The last byte of a read is refused so that the target lets go of SDA.
  task automatic get(output logic [7:0] b, input logic last);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(last, s);
  endtask : get
endmodule : gsi_host_model
`default_nettype wire

/* File: tb_i2c_register_access_port.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_register_access_port
  import gsi_pkg::*;
;
  logic       ref_clk_in = 1'b0;
  logic       link_clk   = 1'b0;
  logic       rst_in     = 1'b1;
  logic       nvm_we     = 1'b0;
  logic [7:0] nvm_addr   = 8'h00;
  logic [7:0] nvm_data   = 8'h00;
  logic       wr_ready   = 1'b1;
  logic       stall      = 1'b0;
  logic       scl_oe, sda_oe, scl_o, sda_o, scl_low, sda_low, wr_valid;
  wire logic  scl;
  wire logic  sda;
  gsi_wr_t    wr;
  gsi_wr_t    seen[$];
  int         bad_count = 0;
  int         samples_checked = 0;
  int         cycles = 0;

  // ----------------------------------------------------------------------
  // Clocks, wires and instances
  // ----------------------------------------------------------------------
  always #4 ref_clk_in = ~ref_clk_in;
  initial #1.3 forever #3 link_clk = ~link_clk;
  assign scl = (scl_oe ? scl_o : 1'b1) & ~scl_low;
  assign sda = (sda_oe ? sda_o : 1'b1) & ~sda_low;

  gsi_i2c_target #(.DEPTH(2)) DUT (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .link_clk_in(link_clk),
    .scl_in(scl), .sda_in(sda), .scl_out(scl_o), .scl_oe_out(scl_oe),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .nvm_we_in(nvm_we),
    .nvm_addr_in(nvm_addr), .nvm_data_in(nvm_data), .wr_valid_out(wr_valid),
    .wr_ready_in(wr_ready), .wr_out(wr));

  gsi_host_model host (.scl_in(scl), .sda_in(sda), .scl_low_out(scl_low),
    .sda_low_out(sda_low));

  always @(posedge ref_clk_in) begin
    wr_ready <= #1 ~stall;
    if (wr_valid === 1'b1 && wr_ready) seen.push_back(wr);
    cycles++;
    if (cycles == 90000) begin
      bad_count++;
      summarize();
    end
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask : chk

  task automatic nvm_load(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    #1;
    nvm_we = 1'b1;
    nvm_addr = a;
    nvm_data = d;
    @(posedge ref_clk_in);
    #1;
    nvm_we = 1'b0;
  endtask : nvm_load

  task automatic send(input logic [6:0] a, input logic [7:0] b[$], output logic [7:0] nacks);
    logic ack;
    host.start();
    host.put({a, 1'b0}, ack);
    nacks = 8'(!ack);
    foreach (b[i]) begin
      host.put(b[i], ack);
      nacks += 8'(!ack);
    end
    host.stop();
  endtask : send

  task automatic fetch(input logic use_ptr, input logic [7:0] ptr, input int n,
                       output logic [7:0] got[$], output logic [7:0] nacks);
    logic       ack;
    logic [7:0] b;
    got = {};
    nacks = 8'h00;
    if (use_ptr) begin
      host.start();
      host.put({TGT_ADDR, 1'b0}, ack);
      nacks += 8'(!ack);
      host.put(ptr, ack);
      nacks += 8'(!ack);
    end
    host.start();
    host.put({TGT_ADDR, 1'b1}, ack);
    nacks += 8'(!ack);
    for (int i = 0; i < n; i++) begin
      host.get(b, i == n - 1);
      got.push_back(b);
    end
    host.stop();
  endtask : fetch

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_other_addr();
    logic [7:0] k;
    send(7'h33, {8'h88, 8'h77}, k);
    chk("nacks to foreign address", 16'h0003, {8'h00, k});
    chk("writes from foreign address", 16'h0000, 16'(seen.size()));
  endtask : t_other_addr

  task automatic t_ram_burst();
    logic [7:0] k;
    seen = {};
    stall = 1'b1;
    fork
      send(TGT_ADDR, {8'h88, 8'h11, 8'h22, 8'h33, 8'h44}, k);
      begin
        repeat (3750) @(posedge ref_clk_in);
        #1;
        chk("valid while stalled", 16'h0001, {15'h0000, wr_valid});
        stall = 1'b0;
      end
    join
    chk("burst nacks", 16'h0000, {8'h00, k});
    chk("burst words", 16'h0004, 16'(seen.size()));
    for (int i = 0; i < 4 && i < seen.size(); i++)
      chk("burst word", {8'(8'h88 + i), 8'(8'h11 * (i + 1))}, seen[i]);
  endtask : t_ram_burst

  task automatic t_read_back();
    logic [7:0] g[$];
    logic [7:0] k;
    host.half_ns = 1250;
    fetch(1'b1, 8'h88, 4, g, k);
    host.half_ns = 300;
    chk("read nacks", 16'h0000, {8'h00, k});
    for (int i = 0; i < 4; i++)
      chk("read back", {8'h00, 8'(8'h11 * (i + 1))}, {8'h00, g[i]});
    // Pointer load at the fastest standard mode rate, then a read at the default rate.
    host.half_ns = 5000;
    send(TGT_ADDR, {8'h8b}, k);
    host.half_ns = 300;
    chk("standard mode nacks", 16'h0000, {8'h00, k});
    fetch(1'b0, 8'h00, 1, g, k);
    chk("standard mode pointer", 16'h0044, {8'h00, g[0]});
  endtask : t_read_back

  task automatic t_nvm_area();
    logic [7:0] g[$];
    logic [7:0] k;
    seen = {};
    nvm_load(8'h10, 8'h5a);
    nvm_load(8'h11, 8'ha5);
    send(TGT_ADDR, {8'h10, 8'h00}, k);
    chk("nvm write nacks", 16'h0000, {8'h00, k});
    fetch(1'b1, 8'h10, 1, g, k);
    chk("nvm kept", 16'h005a, {8'h00, g[0]});
    fetch(1'b0, 8'h00, 1, g, k);
    chk("pointer carried", 16'h00a5, {8'h00, g[0]});
    chk("nvm notifications", 16'h0000, 16'(seen.size()));
  endtask : t_nvm_area

  task automatic t_wrap();
    logic [7:0] g[$];
    logic [7:0] k;
    seen = {};
    nvm_load(8'h00, 8'hc3);
    send(TGT_ADDR, {8'hfe, 8'h01, 8'h02, 8'h03}, k);
    chk("wrap words", 16'h0002, 16'(seen.size()));
    chk("last ram word", 16'hff02, seen[$]);
    fetch(1'b1, 8'hff, 2, g, k);
    chk("read at top", 16'h0002, {8'h00, g[0]});
    chk("read after wrap", 16'h00c3, {8'h00, g[1]});
  endtask : t_wrap

  task automatic summarize();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (12) @(posedge ref_clk_in);
    #1;
    rst_in = 1'b0;
    repeat (10) @(posedge ref_clk_in);
    t_other_addr();
    t_ram_burst();
    t_read_back();
    t_nvm_area();
    t_wrap();
    summarize();
  end
endmodule : tb_i2c_register_access_port
`default_nettype wire
